// ---- bench/plf_pin_model.sv ----
// far side of one port: external drivers and wire level
// assumes active-low output enables from the fabric
`timescale 1ns/1ps
`default_nettype none
module plf_pin_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_out_en_n,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	// outside drivers back off wherever the fabric drives, so no contention
	assign pin_in = (~pin_out_en_n & pin_out) | (pin_out_en_n & ext_val);
endmodule
`default_nettype wire

// ---- bench/port_logic_fabric_bench.sv ----
// self-checking bench for the port logic fabric
// assumes plf_pin_model on the pins and the plain register port
`timescale 1ns/1ps
`default_nettype none
module port_logic_fabric_bench;
	logic ref_clk, srst, reg_wr, reg_rd;
	logic [7:0] reg_addr, pin_in, pin_out, pin_out_en_n, mtx_out, mtx_out_en_n, mtx_in;
	logic [7:0] res_in, ext, v;
	logic [31:0] reg_wdata, reg_rdata, d1, d2;
	logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h3c, 8'h10, 8'hfc};
	int n_mismatch, cmp_count;
	plf_pkg::plf_lut_cfg_t cfg [8];
	plf_fabric #(.PORT_NUM(8), .NUM_LUT(8)) DUT (.ref_clk(ref_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_out_en_n(pin_out_en_n), .mtx_out(mtx_out), .mtx_out_en_n(mtx_out_en_n),
		.mtx_in(mtx_in), .res_in(res_in));
	plf_pin_model pins (.pin_out(pin_out), .pin_out_en_n(pin_out_en_n), .ext_val(ext),
		.pin_in(pin_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// two reads back to back, one cycle apart
	task automatic rd2(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		#1 d1 = reg_rdata;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d2 = reg_rdata;
	endtask
	task automatic drv(input logic [7:0] e, input logic [7:0] r, input logic [7:0] mo,
		input logic [7:0] me);
		@(posedge ref_clk);
		ext <= e;
		res_in <= r;
		mtx_out <= mo;
		mtx_out_en_n <= me;
	endtask
	// synchroniser, a chain of up to eight registered tables, then the output flop
	task automatic settle;
		repeat (14) @(posedge ref_clk);
		#1;
	endtask
	function automatic logic pick(input logic [4:0] s, input logic [7:0] y,
		input logic [7:0] p, input logic [7:0] r);
		if (s < 5'h08) return y[s[2:0]];
		if (s < 5'h10) return p[s[2:0]];
		if (s < 5'h18) return r[s[2:0]];
		return 1'b0;
	endfunction
	function automatic logic [7:0] lut_exp(input logic [7:0] p, input logic [7:0] r);
		logic [7:0] y;
		y = 8'h00;
		for (int i = 0; i < 8; i++) begin
			y[i] = cfg[i].tt[{pick(cfg[i].sel2, y, p, r), pick(cfg[i].sel1, y, p, r),
				pick(cfg[i].sel0, y, p, r)}];
		end
		return y;
	endfunction
	// operand a = 8'ha6 from resources, b = 8'h3c from pins
	function automatic logic [7:0] du_exp(input int op, input logic [7:0] p);
		case (op)
			0: return p;
			1: return 8'ha6;
			2: return p + 8'h01;
			3: return p - 8'h01;
			4: return {p[6:0], 1'b0};
			5: return 8'h24;
			6: return 8'hbe;
			default: return 8'h9a;
		endcase
	endfunction
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		ext = 8'h00;
		res_in = 8'h00;
		mtx_out = 8'h00;
		mtx_out_en_n = 8'hff;
		n_mismatch = 0;
		cmp_count = 0;
		void'($urandom(81116));
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		wr(8'h10, 32'hffffffff);
		foreach (ra[k]) begin
			rd2(ra[k]);
			chk("reset or unmapped read", d1, 32'h0);
		end
		$display("reset test done");
		repeat (8) begin
			drv(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
			@(posedge ref_clk);
			#1;
			chk("bypass out", pin_out, mtx_out);
			chk("out enable", pin_out_en_n, mtx_out_en_n);
			settle;
			chk("bypass in", mtx_in, pin_in);
		end
		$display("bypass test done");
		repeat (3) begin
			// lower-numbered sources only, so no combinational loop
			for (int i = 0; i < 8; i++) begin
				cfg[i].sel2 = (i == 0) ? 5'h19 : 5'($urandom % i);
				cfg[i].sel1 = 5'h10 + 5'($urandom % 8);
				cfg[i].sel0 = 5'h08 + 5'($urandom % 8);
				cfg[i].sync = 1'($urandom);
				cfg[i].tt = 8'($urandom);
				wr(8'h20 + 8'(4 * i), 32'(cfg[i]));
			end
			wr(8'h00, 32'h1);
			repeat (4) begin
				drv(8'($urandom), 8'($urandom), 8'($urandom), 8'hff);
				settle;
				v = lut_exp(pin_in, res_in);
				chk("lut to pin", pin_out, v);
				chk("lut to matrix", mtx_in, v);
				rd2(8'h0c);
				chk("lut status", d1[7:0], v);
			end
		end
		$display("lookup test done");
		for (int s = 0; s < 2; s++) begin
			wr(8'h20, {8'h00, 5'h19, 5'h19, 5'h08, 1'(s), 8'haa});
			drv(8'h00, 8'h00, 8'h00, 8'hff);
			settle;
			drv(8'h01, 8'h00, 8'h00, 8'hff);
			repeat (3) @(posedge ref_clk);
			#1;
			chk("lut latency", pin_out[0], 1'(s == 0));
			@(posedge ref_clk);
			#1;
			chk("lut latency", pin_out[0], 1'b1);
		end
		$display("latency test done");
		wr(8'h08, 32'h5a);
		drv(8'h3c, 8'ha6, 8'h00, 8'hff);
		wr(8'h04, 32'h11);
		settle;
		rd2(8'h0c);
		chk("unit register load", d1[23:16], 8'h5a);
		chk("unit match flag", d1[8], 1'b1);
		for (int op = 0; op < 8; op++) begin
			wr(8'h04, 32'h09);
			settle;
			wr(8'h04, 32'h08 | 32'(op));
			rd2(8'h0c);
			chk("unit result", d2[23:16], du_exp(op, d1[23:16]));
		end
		$display("data unit test done");
		wr(8'h00, 32'h0);
		drv(8'h00, 8'h00, 8'h96, 8'hff);
		@(posedge ref_clk);
		#1;
		chk("bypass after disable", pin_out, 8'h96);
		wrap_up;
	end
endmodule
`default_nettype wire

// ---- verilog/plf_defines.svh ----
// register offsets, field positions and reset values of the port logic fabric
// assumes a byte-addressed plain register port with 32-bit data words
`ifndef PLF_DEFINES_SVH
`define PLF_DEFINES_SVH

`define PLF_OFF_CTRL 8'h00
`define PLF_OFF_DU_CTRL 8'h04
`define PLF_OFF_DU_REG 8'h08
`define PLF_OFF_STATUS 8'h0c
// lookup_table configs at 8'h20 + 4*i, i = 0..7
`define PLF_LUT_PAGE 3'h1

`define PLF_CTRL_EN_BIT 0
`define PLF_DU_CTRL_W 7
`define PLF_LUT_CFG_W 24
`define PLF_STAT_DU_OUT_BIT 8
`define PLF_STAT_DU_DATA_LSB 16

// lookup_table source select codes
`define PLF_SRC_LUT_BASE 5'h00
`define PLF_SRC_PIN_BASE 5'h08
`define PLF_SRC_RES_BASE 5'h10
`define PLF_SRC_DU 5'h18

`define PLF_RST_DU_CTRL 7'h00
`define PLF_RST_DU_REG 8'h00
`define PLF_RST_LUT_CFG 24'h000000
`define PLF_RST_OE_N 8'hff

`endif

// ---- verilog/plf_fabric.sv ----
// port logic fabric: eight lookup_table blocks and a data_unit on one port
// assumes pins are asynchronous, matrix and resources run on ref_clk
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "plf_defines.svh"

module plf_fabric #(
	parameter int PORT_NUM = 8,
	parameter int NUM_LUT = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_out_en_n,
	input wire logic [7:0] mtx_out,
	input wire logic [7:0] mtx_out_en_n,
	output logic [7:0] mtx_in,
	input wire logic [7:0] res_in
);

	plf_pkg::plf_state_t st;
	plf_pkg::plf_state_t next_st;
	logic [7:0] lut_y;
	logic [24:0] src_bus;
	logic du_out;
	logic [7:0] du_a;
	logic [7:0] du_b;
	logic [7:0] du_result;
	logic lut_hit;

	// serves one port only; PORT_NUM must be 8 or 9

	function automatic logic [7:0] du_pick(input plf_pkg::plf_du_src_t s,
		input logic [7:0] pins, input logic [7:0] res, input logic [7:0] rv);
		logic [7:0] v;
		v = 8'h00;
		unique case (s)
			plf_pkg::PLF_SRC_PINS: v = pins;
			plf_pkg::PLF_SRC_RES: v = res;
			plf_pkg::PLF_SRC_REG: v = rv;
			plf_pkg::PLF_SRC_ZERO: v = 8'h00;
		endcase
		return v;
	endfunction

	function automatic logic src_pick(input logic [24:0] bus, input logic [4:0] sel);
		logic b;
		b = 1'b0;
		if (sel <= `PLF_SRC_DU) begin
			b = bus[sel];
		end
		return b;
	endfunction

	// source order: lookup_tables, synced pins, resources, data_unit
	assign src_bus = {du_out, res_in, st.pin_s2, lut_y};

	// operand choice
	assign du_a = du_pick(st.du_ctrl.src_a, st.pin_s2, res_in, st.du_reg);
	assign du_b = du_pick(st.du_ctrl.src_b, st.pin_s2, res_in, st.du_reg);
	assign du_out = (st.du_data == st.du_reg);
	assign lut_hit = (reg_addr[7:5] == `PLF_LUT_PAGE) && (reg_addr[1:0] == 2'h0);

	// opcode selected function
	always_comb begin
		du_result = st.du_data;
		unique case (st.du_ctrl.op)
			plf_pkg::PLF_DU_HOLD: du_result = st.du_data;
			plf_pkg::PLF_DU_LOAD_A: du_result = du_a;
			plf_pkg::PLF_DU_INC: du_result = st.du_data + 8'h01;
			plf_pkg::PLF_DU_DEC: du_result = st.du_data - 8'h01;
			plf_pkg::PLF_DU_SHIFT: du_result = {st.du_data[6:0], du_a[0]};
			plf_pkg::PLF_DU_AND: du_result = du_a & du_b;
			plf_pkg::PLF_DU_OR: du_result = du_a | du_b;
			plf_pkg::PLF_DU_XOR: du_result = du_a ^ du_b;
		endcase
	end

	// eight tables, three independently selected inputs each
	// async tables feeding each other in a ring form a loop; software must avoid it
	for (genvar i = 0; i < NUM_LUT; i++) begin : g_lut
		plf_lookup_table u_lut (
			.ref_clk(ref_clk),
			.srst(srst),
			.cfg(st.lut_cfg[i]),
			.in_bits({src_pick(src_bus, st.lut_cfg[i].sel2),
				src_pick(src_bus, st.lut_cfg[i].sel1),
				src_pick(src_bus, st.lut_cfg[i].sel0)}),
			.y(lut_y[i])
		);
	end

	always_comb begin
		next_st = st;
		// first stage feeds only the second stage
		next_st.pin_s1 = pin_in;
		next_st.pin_s2 = st.pin_s1;
		next_st.rdata = 32'h0000_0000;
		if (reg_wr) begin
			unique case (reg_addr)
				`PLF_OFF_CTRL: next_st.enable = reg_wdata[`PLF_CTRL_EN_BIT];
				`PLF_OFF_DU_CTRL: next_st.du_ctrl = plf_pkg::plf_du_ctrl_t'(reg_wdata[`PLF_DU_CTRL_W-1:0]);
				`PLF_OFF_DU_REG: next_st.du_reg = reg_wdata[7:0];
				default: begin
					if (lut_hit) begin
						next_st.lut_cfg[reg_addr[4:2]] = reg_wdata[`PLF_LUT_CFG_W-1:0];
					end
				end
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`PLF_OFF_CTRL: next_st.rdata[`PLF_CTRL_EN_BIT] = st.enable;
				`PLF_OFF_DU_CTRL: next_st.rdata[`PLF_DU_CTRL_W-1:0] = st.du_ctrl;
				`PLF_OFF_DU_REG: next_st.rdata[7:0] = st.du_reg;
				`PLF_OFF_STATUS: begin
					next_st.rdata[7:0] = lut_y;
					next_st.rdata[`PLF_STAT_DU_OUT_BIT] = du_out;
					next_st.rdata[`PLF_STAT_DU_DATA_LSB +: 8] = st.du_data;
				end
				default: begin
					if (lut_hit) begin
						next_st.rdata[`PLF_LUT_CFG_W-1:0] = st.lut_cfg[reg_addr[4:2]];
					end
				end
			endcase
		end
		// runs on its own every cycle while enable is set, no software step needed
		if (st.enable) begin
			next_st.du_data = du_result;
		end
		if (st.enable) begin
			next_st.pin_out = lut_y;
			next_st.mtx_in = lut_y;
		end else begin
			next_st.pin_out = mtx_out;
			next_st.mtx_in = st.pin_s2;
		end
		// the matrix keeps control of direction either way
		next_st.pin_out_en_n = mtx_out_en_n;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
			st.du_ctrl <= `PLF_RST_DU_CTRL;
			st.du_reg <= `PLF_RST_DU_REG;
			st.lut_cfg <= {NUM_LUT{`PLF_RST_LUT_CFG}};
			st.pin_out_en_n <= `PLF_RST_OE_N;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign pin_out = st.pin_out;
	assign pin_out_en_n = st.pin_out_en_n;
	assign mtx_in = st.mtx_in;

	a_port_number: assert property (@(posedge ref_clk)
		PORT_NUM == 8 || PORT_NUM == 9)
		else $error("fabric placed on an unsupported port");
	a_bypass_out: assert property (@(posedge ref_clk) disable iff (srst)
		!st.enable |=> pin_out == $past(mtx_out))
		else $error("bypass outbound path broken");
	a_bypass_in: assert property (@(posedge ref_clk) disable iff (srst)
		!st.enable ##1 !st.enable ##1 !st.enable |=> mtx_in == $past(pin_in, 3))
		else $error("bypass inbound path broken");
	a_fabric_out: assert property (@(posedge ref_clk) disable iff (srst)
		st.enable |=> pin_out == $past(lut_y) && mtx_in == $past(lut_y))
		else $error("fabric output not taken from lookup_tables");
	a_du_count: assert property (@(posedge ref_clk) disable iff (srst)
		st.enable && st.du_ctrl.op == plf_pkg::PLF_DU_INC && !reg_wr
		|=> st.du_data == 8'($past(st.du_data) + 8'h01))
		else $error("data_unit increment wrong");
	a_du_load_reg: assert property (@(posedge ref_clk) disable iff (srst)
		st.enable && st.du_ctrl.op == plf_pkg::PLF_DU_LOAD_A
		&& st.du_ctrl.src_a == plf_pkg::PLF_SRC_REG |=> st.du_data == $past(st.du_reg))
		else $error("data_unit register operand not loaded");
	a_du_free_run: assert property (@(posedge ref_clk) disable iff (srst)
		st.enable && st.du_ctrl.op == plf_pkg::PLF_DU_DEC && !reg_wr && !reg_rd
		##1 !reg_wr && !reg_rd |=> st.du_data == 8'($past(st.du_data, 2) - 8'h02))
		else $error("data_unit stalled without bus activity");
	a_read_ctrl: assert property (@(posedge ref_clk) disable iff (srst)
		reg_rd && reg_addr == `PLF_OFF_CTRL |=> reg_rdata == {31'h0, $past(st.enable)}
		##1 (reg_rdata == 32'h0 || $past(reg_rd)))
		else $error("control readback wrong or held too long");

	c_enable_on: cover property (@(posedge ref_clk) disable iff (srst)
		!st.enable ##1 st.enable);
	c_du_match: cover property (@(posedge ref_clk) disable iff (srst)
		st.enable && du_out);
	c_lut_sync: cover property (@(posedge ref_clk) disable iff (srst)
		st.enable && st.lut_cfg[0].sync && lut_y[0]);
	c_status_read: cover property (@(posedge ref_clk) disable iff (srst)
		reg_rd && reg_addr == `PLF_OFF_STATUS);

endmodule

`default_nettype wire

// ---- verilog/plf_lookup_table.sv ----
// one three-input lookup_table with optional output register
// assumes its three inputs already selected by the fabric
`timescale 1ns/1ps
`default_nettype none

module plf_lookup_table (
	input wire logic ref_clk,
	input wire logic srst,
	input wire plf_pkg::plf_lut_cfg_t cfg,
	input wire logic [2:0] in_bits,
	output logic y
);

	plf_pkg::plf_lut_state_t st;
	plf_pkg::plf_lut_state_t next_st;
	logic table_bit;

	assign table_bit = cfg.tt[in_bits];

	always_comb begin
		next_st = st;
		next_st.y = table_bit;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// combinational or clocked output
	assign y = cfg.sync ? st.y : table_bit;

	a_lut_sync_reg: assert property (@(posedge ref_clk) disable iff (srst)
		cfg.sync ##1 cfg.sync && $stable(cfg) |-> y == $past(cfg.tt[in_bits]))
		else $error("registered lookup_table output mismatch");
	a_lut_async_idx: assert property (@(posedge ref_clk) disable iff (srst)
		!cfg.sync && in_bits == 3'h5 |-> y == cfg.tt[5])
		else $error("combinational lookup_table picked wrong bit");

endmodule

`default_nettype wire

// ---- verilog/plf_pkg.sv ----
// types shared by the port logic fabric and its lookup_table blocks
// assumes plf_defines.svh for numeric constants
package plf_pkg;

	typedef enum logic [2:0] {
		PLF_DU_HOLD,
		PLF_DU_LOAD_A,
		PLF_DU_INC,
		PLF_DU_DEC,
		PLF_DU_SHIFT,
		PLF_DU_AND,
		PLF_DU_OR,
		PLF_DU_XOR
	} plf_du_op_t;

	typedef enum logic [1:0] {
		PLF_SRC_PINS,
		PLF_SRC_RES,
		PLF_SRC_REG,
		PLF_SRC_ZERO
	} plf_du_src_t;

	typedef struct packed {
		plf_du_src_t src_b;
		plf_du_src_t src_a;
		plf_du_op_t op;
	} plf_du_ctrl_t;

	typedef struct packed {
		logic [4:0] sel2;
		logic [4:0] sel1;
		logic [4:0] sel0;
		logic sync;
		logic [7:0] tt;
	} plf_lut_cfg_t;

	typedef struct packed {
		logic y;
	} plf_lut_state_t;

	typedef struct packed {
		logic [7:0] pin_s1;
		logic [7:0] pin_s2;
		logic enable;
		plf_du_ctrl_t du_ctrl;
		logic [7:0] du_reg;
		logic [7:0] du_data;
		plf_lut_cfg_t [7:0] lut_cfg;
		logic [7:0] pin_out;
		logic [7:0] pin_out_en_n;
		logic [7:0] mtx_in;
		logic [31:0] rdata;
	} plf_state_t;

endpackage
